// ===== spl_pkg.sv
// Purpose: Shared constants and types of the serial configuration loader
// Assumes: pclk at 50 MHz, link clock at 64 ns
// Notes:   Offsets are byte addresses on a 32-bit APB; bit positions index the 32-bit data word
`default_nettype none
package spl_pkg;
    // ****************************************
    // Clocks and serial timing
    // ****************************************
    localparam int unsigned PCLK_NS     = 20;
    localparam int unsigned LINK_NS     = 64;
    localparam int unsigned T_SLOW_NS   = 4000;
    localparam int unsigned T_FAST_NS   = 800;
    localparam int unsigned HALF_SLOW   = T_SLOW_NS / (2 * LINK_NS);
    localparam int unsigned HALF_FAST   = T_FAST_NS / (2 * LINK_NS);
    localparam int unsigned STRAP_WAIT  = 4;
    localparam int unsigned DIV_W       = 8;
    // ****************************************
    // Bus speed codes
    // ****************************************
    localparam logic [1:0]  SPEED_125   = 2'h0;
    localparam logic [1:0]  SPEED_25    = 2'h3;
    localparam logic [1:0]  SPEED_RST   = 2'h3;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] OFF_CTRL    = 12'h000;
    localparam logic [11:0] OFF_STAT    = 12'h004;
    localparam logic [11:0] OFF_CFG     = 12'h040;
    localparam int unsigned CTRL_SPEED  = 0;
    localparam int unsigned CTRL_RELOAD = 8;
    localparam int unsigned ST_PRESENT  = 0;
    localparam int unsigned ST_BIGEND   = 1;
    localparam int unsigned ST_BUS16    = 2;
    localparam int unsigned ST_BUSY     = 3;
    localparam int unsigned ST_LOADED   = 4;
    localparam int unsigned ST_LATCHED  = 5;
    // ****************************************
    // Serial memory format
    // ****************************************
    localparam int unsigned CMD_BITS    = 3;
    localparam int unsigned ADDR_BITS   = 6;
    localparam int unsigned WORD_BITS   = 16;
    localparam int unsigned CFG_WORDS   = 8;
    localparam int unsigned IDX_W       = 3;
    localparam logic [2:0]  CMD_READ    = 3'h6;
    localparam logic [15:0] CFG_DEFAULT = 16'h0000;
    typedef struct packed {
        logic present;
        logic big_endian;
        logic bus16;
    } spl_strap_t;
    typedef struct packed {
        logic [IDX_W-1:0]     idx;
        logic [WORD_BITS-1:0] data;
    } spl_word_t;
endpackage
`default_nettype wire

// ===== spl_cfg_mem.sv
// Purpose: Small store for the loaded configuration words
// Assumes: Single clock, one write and one read port
// Notes:   Read data come out of a register, one cycle after the address
`default_nettype none
module spl_cfg_mem #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_ff [DEPTH];

    // ****************************************
    // Storage, no reset on the array
    // ****************************************
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_ff[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_ff[rd_addr];
        end
    end
endmodule
`default_nettype wire

// ===== spl_loader.sv
// Purpose: Serial configuration memory loader with APB registers
// Assumes: Straps held stable around reset release; link clock free running
// Notes:   Serial engine runs on link_clk; words cross by toggle handshake
//
// Behaviour
// - Enable strap high means memory present; low or open means absent.
// - Drive a chip-select output that selects the memory during loading.
// - Shift command and address bits out on the data-out pin.
// - Generate the serial clock and shift configuration data in with it.
// - Bus speed code 11 gives a 4 us serial clock period; the divider gives 3968 ns (2 x 31 link cycles).
// - Bus speed code 00 gives an 800 ns serial clock period; the divider gives 768 ns (2 x 6 link cycles).
// - Latch clock pin level as byte order at reset before driving it.
// - With memory present, take configuration bits from the data-in pin.
// - Without memory, latch data-in level as bus width: low 8, high 16.
`default_nettype none
module spl_loader (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        link_clk,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    input  wire logic        serial_prom_enable_strap,
    output logic             serial_prom_select,
    output logic             serial_prom_data_out,
    input  wire logic        serial_prom_data_in,
    input  wire logic        serial_prom_clock_in,
    output logic             serial_prom_clock_out,
    output logic             serial_prom_clock_oe,
    output spl_pkg::spl_strap_t strap_cfg,
    output logic             strap_latched,
    output logic             cfg_loaded
);
    import spl_pkg::*;

    typedef enum logic [4:0] {
        LS_IDLE  = 5'h01,
        LS_SHIFT = 5'h02,
        LS_READ  = 5'h04,
        LS_HAND  = 5'h08,
        LS_GAP   = 5'h10
    } spl_lstate_t;

    localparam int unsigned OUT_BITS = CMD_BITS + ADDR_BITS;

    function automatic logic [DIV_W-1:0] half_of(input logic [1:0] spd);
        half_of = (spd == SPEED_125) ? DIV_W'(HALF_FAST) : DIV_W'(HALF_SLOW);
    endfunction

    function automatic logic is_reg(input logic [11:0] a, input logic [11:0] off);
        is_reg = (a == off);
    endfunction

    // ****************************************
    // Pin synchronisers (pclk)
    // ****************************************
    logic en_s1_ff, en_s2_ff, din_s1_ff, din_s2_ff, sck_s1_ff, sck_s2_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_s1_ff, en_s2_ff}   <= 2'h0;
            {din_s1_ff, din_s2_ff} <= 2'h0;
            {sck_s1_ff, sck_s2_ff} <= 2'h0;
        end else begin
            {en_s1_ff, en_s2_ff}   <= {serial_prom_enable_strap, en_s1_ff};
            {din_s1_ff, din_s2_ff} <= {serial_prom_data_in, din_s1_ff};
            {sck_s1_ff, sck_s2_ff} <= {serial_prom_clock_in, sck_s1_ff};
        end
    end

    // ****************************************
    // Strap capture after reset release
    // ****************************************
    logic [2:0]  wait_ff;
    spl_strap_t  strap_ff;
    logic        latched_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff    <= '0;
            latched_ff <= 1'b0;
            strap_ff   <= '0;
        end else if (!latched_ff) begin
            // Let the synchronisers fill before trusting the pins
            wait_ff <= wait_ff + 3'h1;
            if (wait_ff == 3'(STRAP_WAIT)) begin
                latched_ff          <= 1'b1;
                strap_ff.present    <= en_s2_ff;
                strap_ff.big_endian <= sck_s2_ff;
                strap_ff.bus16      <= din_s2_ff;
            end
        end
    end
    assign strap_cfg     = strap_ff;
    assign strap_latched = latched_ff;

    // ****************************************
    // APB slave
    // ****************************************
    logic        ack_ff, busy_ff, loaded_ff, start_tgl_ff;
    logic [1:0]  speed_ff;
    logic [31:0] prdata_ff;
    logic        pslverr_ff;
    logic [15:0] mem_rd;
    logic        acc, hit_cfg, hit_any, wr_go, reload_req;

    assign acc     = psel && penable;
    assign hit_cfg = (paddr >= OFF_CFG) && (paddr < OFF_CFG + 12'(4 * CFG_WORDS))
                     && (paddr[1:0] == 2'h0);
    assign hit_any = is_reg(paddr, OFF_CTRL) || is_reg(paddr, OFF_STAT) || hit_cfg;
    assign wr_go   = acc && ack_ff && pwrite;
    assign pready  = acc && ack_ff;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff && pready;

    // One wait state: memory data and the read mux settle into flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_ff     <= 1'b0;
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end else if (acc && !ack_ff) begin
            ack_ff     <= 1'b1;
            pslverr_ff <= !hit_any;
            prdata_ff  <= '0;
            if (!pwrite) begin
                if (is_reg(paddr, OFF_CTRL)) begin
                    prdata_ff[CTRL_SPEED +: 2] <= speed_ff;
                end else if (is_reg(paddr, OFF_STAT)) begin
                    prdata_ff[ST_PRESENT] <= strap_ff.present;
                    prdata_ff[ST_BIGEND]  <= strap_ff.big_endian;
                    prdata_ff[ST_BUS16]   <= strap_ff.bus16;
                    prdata_ff[ST_BUSY]    <= busy_ff;
                    prdata_ff[ST_LOADED]  <= loaded_ff;
                    prdata_ff[ST_LATCHED] <= latched_ff;
                end else if (hit_cfg) begin
                    // Defaults stand until a load has completed
                    prdata_ff[15:0] <= loaded_ff ? mem_rd : CFG_DEFAULT;
                end
            end
        end else begin
            ack_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed_ff <= SPEED_RST;
        end else if (wr_go && is_reg(paddr, OFF_CTRL)) begin
            speed_ff <= pwdata[CTRL_SPEED +: 2];
        end
    end

    // ****************************************
    // Load control and word receive (pclk)
    // ****************************************
    spl_word_t   word_ff;
    logic        req_tgl_ff, req_s1_ff, req_s2_ff, req_seen_ff, ack_tgl_ff, auto_ff;
    logic        word_in;

    assign reload_req = wr_go && is_reg(paddr, OFF_CTRL) && pwdata[CTRL_RELOAD];
    assign word_in    = req_s2_ff != req_seen_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {req_s1_ff, req_s2_ff, req_seen_ff} <= 3'h0;
        end else begin
            {req_s1_ff, req_s2_ff} <= {req_tgl_ff, req_s1_ff};
            req_seen_ff            <= req_s2_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_ff      <= 1'b0;
            busy_ff      <= 1'b0;
            loaded_ff    <= 1'b0;
            start_tgl_ff <= 1'b0;
            ack_tgl_ff   <= 1'b0;
        end else begin
            auto_ff <= latched_ff;
            // No load without a present memory, nor before straps are known
            if (latched_ff && strap_ff.present && !busy_ff &&
                ((latched_ff && !auto_ff) || reload_req)) begin
                busy_ff      <= 1'b1;
                loaded_ff    <= 1'b0;
                start_tgl_ff <= !start_tgl_ff;
            end else if (word_in) begin
                ack_tgl_ff <= !ack_tgl_ff;
                if (word_ff.idx == IDX_W'(CFG_WORDS - 1)) begin
                    busy_ff   <= 1'b0;
                    loaded_ff <= 1'b1;
                end
            end
        end
    end
    assign cfg_loaded = loaded_ff;

    // Word register is held by the link side until the ack returns
    spl_cfg_mem #(.WIDTH(WORD_BITS), .DEPTH(CFG_WORDS), .AW(IDX_W)) u_mem (
        .clk     (pclk),
        .rst_n   (presetn),
        .wr_en   (word_in),
        .wr_addr (word_ff.idx),
        .wr_data (word_ff.data),
        .rd_addr (paddr[2 +: IDX_W]),
        .rd_data (mem_rd)
    );

    // ****************************************
    // Link domain synchronisers
    // ****************************************
    logic       lrst_s1_ff, lrst_n;
    logic       st_s1_ff, st_s2_ff, st_seen_ff, st_old_ff, ak_s1_ff, ak_s2_ff;
    logic       ld_s1_ff, ld_s2_ff;
    logic [1:0] sp_s1_ff, sp_s2_ff;
    always_ff @(posedge link_clk or negedge presetn) begin
        if (!presetn) begin
            {lrst_s1_ff, lrst_n} <= 2'h0;
        end else begin
            {lrst_s1_ff, lrst_n} <= {1'b1, lrst_s1_ff};
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            {st_s1_ff, st_s2_ff, st_seen_ff, st_old_ff} <= 4'h0;
            {ak_s1_ff, ak_s2_ff}             <= 2'h0;
            {ld_s1_ff, ld_s2_ff}             <= 2'h0;
            sp_s1_ff <= SPEED_RST;
            sp_s2_ff <= SPEED_RST;
        end else begin
            {st_s1_ff, st_s2_ff}   <= {start_tgl_ff, st_s1_ff};
            st_seen_ff             <= st_s2_ff;
            st_old_ff              <= st_seen_ff;
            {ak_s1_ff, ak_s2_ff}   <= {ack_tgl_ff, ak_s1_ff};
            {ld_s1_ff, ld_s2_ff}   <= {serial_prom_data_in, ld_s1_ff};
            sp_s1_ff               <= speed_ff;
            sp_s2_ff               <= sp_s1_ff;
        end
    end

    // ****************************************
    // Serial engine (link_clk)
    // ****************************************
    spl_lstate_t             lstate_ff;
    logic [DIV_W-1:0]        div_ff, half_ff, hi_cnt_ff;
    logic [1:0]              spd_ff;
    logic                    sck_ff, sel_ff, dout_ff, oe_ff, tick;
    logic [4:0]              bit_ff;
    logic [OUT_BITS-1:0]     osr_ff;
    logic [WORD_BITS-1:0]    isr_ff;
    logic [IDX_W-1:0]        idx_ff;

    assign tick = (div_ff == '0);

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            div_ff <= '0;
        end else if (lstate_ff == LS_IDLE || tick) begin
            div_ff <= half_ff - DIV_W'(1);
        end else begin
            div_ff <= div_ff - DIV_W'(1);
        end
    end

    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            lstate_ff  <= LS_IDLE;
            half_ff    <= DIV_W'(HALF_SLOW);
            spd_ff     <= SPEED_RST;
            sck_ff     <= 1'b0;
            sel_ff     <= 1'b0;
            dout_ff    <= 1'b0;
            oe_ff      <= 1'b0;
            bit_ff     <= '0;
            osr_ff     <= '0;
            isr_ff     <= '0;
            idx_ff     <= '0;
            req_tgl_ff <= 1'b0;
            word_ff    <= '0;
        end else begin
            case (lstate_ff)
                LS_IDLE: begin
                    // One stage late, so the two speed bits have surely settled
                    if (st_seen_ff != st_old_ff) begin
                        // Speed is taken once per load; change it only while idle
                        spd_ff    <= sp_s2_ff;
                        half_ff   <= half_of(sp_s2_ff);
                        idx_ff    <= '0;
                        oe_ff     <= 1'b1;
                        sel_ff    <= 1'b1;
                        osr_ff    <= {CMD_READ, ADDR_BITS'(0)};
                        dout_ff   <= CMD_READ[CMD_BITS-1];
                        bit_ff    <= '0;
                        lstate_ff <= LS_SHIFT;
                    end
                end
                LS_SHIFT: begin
                    if (tick) begin
                        sck_ff <= !sck_ff;
                        if (sck_ff) begin
                            osr_ff  <= {osr_ff[OUT_BITS-2:0], 1'b0};
                            dout_ff <= osr_ff[OUT_BITS-2];
                            bit_ff  <= bit_ff + 5'h1;
                            if (bit_ff == 5'(OUT_BITS - 1)) begin
                                bit_ff    <= '0;
                                dout_ff   <= 1'b0;
                                lstate_ff <= LS_READ;
                            end
                        end
                    end
                end
                LS_READ: begin
                    if (tick) begin
                        sck_ff <= !sck_ff;
                        if (!sck_ff) begin
                            isr_ff <= {isr_ff[WORD_BITS-2:0], ld_s2_ff};
                        end else begin
                            bit_ff <= bit_ff + 5'h1;
                            if (bit_ff == 5'(WORD_BITS - 1)) begin
                                sel_ff       <= 1'b0;
                                word_ff.idx  <= idx_ff;
                                word_ff.data <= isr_ff;
                                req_tgl_ff   <= !req_tgl_ff;
                                lstate_ff    <= LS_HAND;
                            end
                        end
                    end
                end
                LS_HAND: begin
                    if (ak_s2_ff == req_tgl_ff) begin
                        if (idx_ff == IDX_W'(CFG_WORDS - 1)) begin
                            oe_ff     <= 1'b0;
                            lstate_ff <= LS_IDLE;
                        end else begin
                            idx_ff    <= idx_ff + IDX_W'(1);
                            lstate_ff <= LS_GAP;
                        end
                    end
                end
                LS_GAP: begin
                    // Select stays low through the ack handshake and until the next divider tick between words
                    if (tick) begin
                        sel_ff    <= 1'b1;
                        osr_ff    <= {CMD_READ, ADDR_BITS'(idx_ff)};
                        dout_ff   <= CMD_READ[CMD_BITS-1];
                        bit_ff    <= '0;
                        lstate_ff <= LS_SHIFT;
                    end
                end
                default: begin
                    lstate_ff <= LS_IDLE;
                end
            endcase
        end
    end

    assign serial_prom_select    = sel_ff;
    assign serial_prom_data_out  = dout_ff;
    assign serial_prom_clock_out = sck_ff;
    assign serial_prom_clock_oe  = oe_ff;

    // ****************************************
    // Checks
    // ****************************************
    always_ff @(posedge link_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            hi_cnt_ff <= '0;
        end else begin
            hi_cnt_ff <= sck_ff ? hi_cnt_ff + DIV_W'(1) : '0;
        end
    end

    strap_en_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(latched_ff) |-> strap_ff.present == $past(en_s2_ff))
        else $error("enable strap not latched");
    bus_width_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(latched_ff) |-> strap_ff.bus16 == $past(din_s2_ff))
        else $error("bus width strap not latched");
    endian_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(latched_ff) |-> strap_ff.big_endian == $past(sck_s2_ff))
        else $error("byte order strap not latched");
    endian_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
        !latched_ff |-> !busy_ff && strap_ff == '0)
        else $error("load or strap value before latch");
    absent_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
        latched_ff && !strap_ff.present |-> !busy_ff && !loaded_ff)
        else $error("load started without memory");
    sel_idle_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        lstate_ff == LS_IDLE |-> !serial_prom_select && !serial_prom_clock_oe)
        else $error("select or clock driven while idle");
    start_bit_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $rose(sel_ff) |-> serial_prom_data_out ##1 serial_prom_data_out[*2])
        else $error("command start bit wrong");
    slow_clk_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $fell(sck_ff) && spd_ff == SPEED_25 |-> hi_cnt_ff == DIV_W'(HALF_SLOW))
        else $error("slow serial clock half period wrong");
    fast_clk_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $fell(sck_ff) && spd_ff == SPEED_125 |-> hi_cnt_ff == DIV_W'(HALF_FAST))
        else $error("fast serial clock half period wrong");
    data_in_a: assert property (@(posedge link_clk) disable iff (!lrst_n)
        $rose(sck_ff) && lstate_ff == LS_READ |-> isr_ff[0] == $past(ld_s2_ff))
        else $error("data bit not sampled at clock rise");
    load_done_c: cover property (@(posedge pclk) disable iff (!presetn) $rose(loaded_ff));
    reload_c: cover property (@(posedge pclk) disable iff (!presetn) reload_req && !busy_ff);
    absent_c: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(latched_ff) && !en_s2_ff);
    fast_c: cover property (@(posedge link_clk) disable iff (!lrst_n)
        $fell(sck_ff) && spd_ff == SPEED_125);
endmodule
`default_nettype wire

// ===== spl_prom_model.sv
// Purpose: Model of the serial configuration memory
// Assumes: Read command and six address bits, then sixteen data bits
// Notes:   Stored word is a fixed function of its address
`default_nettype none
module spl_prom_model (
    input  wire logic   sel,
    input  wire logic   sck,
    input  wire logic   din,
    output logic        dout,
    output int unsigned bad_cnt,
    output int unsigned word_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    import spl_pkg::*;
    logic [8:0]  cmd;
    logic [15:0] sh;
    int unsigned nbit;
    initial begin
        dout = 1'b0;
        bad_cnt = 0;
        word_cnt = 0;
        nbit = 0;
    end
    always @(posedge sel) nbit = 0;
    always @(posedge sck) if (sel) begin
        if (nbit < 9) cmd = {cmd[7:0], din};
        nbit = nbit + 1;
        if (nbit == 9) begin
            if (cmd !== {CMD_READ, 6'(word_cnt % 8)}) bad_cnt = bad_cnt + 1;
            sh = 16'h8001 + 16'(cmd[5:0]) * 16'h1357;
        end
    end
    // D15 must be ready before the first read rise
    always @(negedge sck) if (sel && nbit >= 9 && nbit < 25) begin
        dout = sh[15];
        sh = sh << 1;
    end
    always @(negedge sel) begin
        dout = 1'b0; // Released line falls to the pin's pull-down
        if (nbit >= 25) word_cnt = word_cnt + 1;
    end
endmodule
`default_nettype wire

// ===== spl_loader_test.sv
// Purpose: Self-checking bench of the serial configuration loader
// Assumes: Memory model on the serial pins
// Notes:   Straps are pull levels seen while pins are not driven
`default_nettype none
module spl_loader_test;
    timeunit 1ns;
    timeprecision 1ps;
    import spl_pkg::*;
    logic        pclk = 1'b0, link_clk = 1'b0, presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic        pready, pslverr, sel, sdo, sck, ck_oe, latched, loaded, mdo, err;
    logic        en_pull = 1'b0, ck_pull = 1'b0, di_pull = 1'b0;
    spl_strap_t  strap;
    int unsigned bad_cnt, word_cnt, error_cnt = 0, samples_checked = 0;
    always #10 pclk = ~pclk;
    always #32 link_clk = ~link_clk;
    spl_loader uut (.pclk(pclk), .presetn(presetn), .link_clk(link_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .serial_prom_enable_strap(en_pull),
        .serial_prom_select(sel), .serial_prom_data_out(sdo),
        .serial_prom_data_in(en_pull ? mdo : di_pull),
        .serial_prom_clock_in(ck_oe ? sck : ck_pull), .serial_prom_clock_out(sck),
        .serial_prom_clock_oe(ck_oe), .strap_cfg(strap), .strap_latched(latched),
        .cfg_loaded(loaded));
    spl_prom_model prom (.sel(sel), .sck(sck), .din(sdo), .dout(mdo),
        .bad_cnt(bad_cnt), .word_cnt(word_cnt));
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(input bit which, input int lim);
        for (int n = 0; (which ? loaded : latched) !== 1'b1; n++) begin
            @(negedge pclk);
            if (n > lim) begin
                chk(32'h0, 32'h1);
                close_out();
            end
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic period(input int unsigned exp);
        realtime t[2];
        int n;
        for (int k = 0; k < 2; k++) begin
            n = 0;
            while (sck !== 1'b0 && n < 200) begin @(negedge link_clk); n++; end
            while (sck !== 1'b1 && n < 200) begin @(negedge link_clk); n++; end
            t[k] = $realtime;
        end
        chk(32'(int'(t[1] - t[0])), exp);
    endtask
    task automatic do_reset(input logic en, input logic ck, input logic di);
        @(posedge pclk);
        presetn <= 1'b0;
        en_pull <= en;
        ck_pull <= ck;
        di_pull <= di;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk({31'h0, ck_oe}, 32'h0);
        wait_hi(1'b0, 50);
    endtask
    task automatic read_words(input int unsigned nw);
        wait_hi(1'b1, 60000);
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, OFF_CFG + 12'(4 * i), 32'h0);
            chk(rd, {16'h0, 16'(16'h8001 + 16'(i) * 16'h1357)});
        end
        chk(word_cnt, nw);
        chk(bad_cnt, 32'h0);
    endtask
    task automatic t_present();
        do_reset(1'b1, 1'b1, 1'b0);
        chk({30'h0, strap.present, strap.big_endian}, 32'h3);
        period(2 * HALF_SLOW * LINK_NS);
        read_words(8);
    endtask
    task automatic t_fast();
        apb(1'b1, OFF_CTRL, 32'h1 << CTRL_RELOAD);
        period(2 * HALF_FAST * LINK_NS);
        read_words(16);
    endtask
    task automatic t_unmapped();
        apb(1'b0, 12'h100, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_absent();
        int n;
        for (int b = 0; b < 2; b++) begin
            do_reset(1'b0, 1'b0, 1'(b));
            chk({29'h0, strap}, 32'(b));
            apb(1'b1, OFF_CTRL, 32'h1 << CTRL_RELOAD);
            n = 0;
            repeat (2000) begin
                @(negedge pclk);
                n += int'(sel | ck_oe);
            end
            chk(32'(n), 32'h0);
            apb(1'b0, OFF_STAT, 32'h0);
            chk(rd, 32'h20 | 32'(b << 2));
            apb(1'b0, OFF_CFG, 32'h0);
            chk(rd, {16'h0, CFG_DEFAULT});
        end
    endtask
    initial begin
        t_present();
        t_fast();
        t_unmapped();
        t_absent();
        close_out();
    end
endmodule
`default_nettype wire
